// ---- logic/standby_mode_control.sv ----
// Purpose: Light and deep standby sequencing, wake timing, clock gating
// Assumes: All inputs synchronous to ref_clk; ref_clk keeps running in standby
// Notes:   sysOscTick marks one system oscillator cycle for the settle wait
`timescale 1ns/1ps
module standby_mode_control
  import standby_pkg::*;
#(
  parameter int NUM_IRQ        = NUM_IRQ_DEF,
  parameter int TIMER_IRQ      = TIMER_IRQ_DEF,
  parameter logic [NUM_IRQ-1:0] STOP_WAKE = STOP_WAKE_DEF[NUM_IRQ-1:0],
  parameter int CNT_W          = 18,
  parameter int OPT_WAIT       = OPT_WAIT_CYC,
  parameter int POST_STOP      = POST_STOP_CYC
) (
  input  wire logic               ref_clk,                // 250 MHz clock
  input  wire logic               rst,                    // Sync reset
  input  wire logic               resetReq,               // Reset signal generation
  input  wire logic               haltInstr,              // Halt instruction pulse
  input  wire logic               stopInstr,              // Stop instruction pulse
  input  wire logic [NUM_IRQ-1:0] irqRequest,             // Request flags
  input  wire logic [NUM_IRQ-1:0] interrupt_mask_flag,    // 1 masks source
  input  wire logic               global_interrupt_enable,// Vectored service on
  input  wire logic [1:0]         osc_settle_select,      // Settle wait code
  input  wire logic               sysOscTick,             // One system osc cycle
  input  wire logic               crystalClock,           // Crystal/ceramic source
  input  wire logic               timerOnLowSpeed,        // Interval timer on slow clk
  input  wire logic               wdtOnLowSpeed,          // Watchdog on slow clk
  input  wire logic               lowSpeedStoppable,      // Slow osc may be stopped
  input  wire logic               lowSpeedStoppedBySw,    // Slow osc stopped now
  output logic                    cpuClockRun,            // CPU clock gate open
  output logic                    sysOscEnable,           // System oscillator on
  output logic                    portLatchHold,          // Port latches frozen
  output logic                    timer16Run,             // 16-bit timer enable
  output logic                    adcRun,                 // A/D converter enable
  output logic                    intervalTimerRun,       // Interval timer enable
  output logic                    watchdogRun,            // Watchdog enable
  output logic                    inHalt,                 // Light standby
  output logic                    inStop,                 // Deep standby
  output logic                    resetFetch,             // Fetch reset vector pulse
  output logic                    vectorTake,             // Take interrupt pulse
  output logic                    resumeNext              // Next instruction pulse
);

  // ---------------------------------------------------------------
  // Wait lengths
  // ---------------------------------------------------------------

  // Settle wait in oscillator cycles for a select code
  function automatic logic [CNT_W-1:0] settleLoad(input logic [1:0] sel);
    logic [CNT_W:0] one;
    one = {{CNT_W{1'b0}}, 1'b1};
    case (sel)
      2'h0:    settleLoad = CNT_W'(one << SETTLE_EXP0);
      2'h1:    settleLoad = CNT_W'(one << SETTLE_EXP1);
      2'h2:    settleLoad = CNT_W'(one << SETTLE_EXP2);
      default: settleLoad = CNT_W'(one << SETTLE_EXP3);
    endcase
  endfunction : settleLoad

  standby_state_t   state_r;
  standby_state_t   state_nxt;
  wake_kind_t       kind_r;
  wake_kind_t       kind_nxt;
  logic [CNT_W-1:0] waitLoad;
  logic             waitStart;
  logic             waitTick;
  logic             waitDone;
  logic             haltWake;
  logic             stopWake;
  logic [NUM_IRQ-1:0] stopSrc;
  logic             resume;

  // ---------------------------------------------------------------
  // Wake conditions
  // ---------------------------------------------------------------

  // Unmasked pending requests and deep standby source filter
  always_comb begin
    stopSrc            = STOP_WAKE;                                     // RULE_11
    stopSrc[TIMER_IRQ] = STOP_WAKE[TIMER_IRQ] & timerOnLowSpeed;        // RULE_12
  end
  assign haltWake = |(irqRequest & ~interrupt_mask_flag);               // RULE_03
  assign stopWake = |(irqRequest & ~interrupt_mask_flag & stopSrc);     // RULE_15

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------

  // Next state and wake cause
  always_comb begin
    state_nxt = state_r;
    kind_nxt  = kind_r;
    case (state_r)
      ST_OPT_WAIT: begin
        // A reset in the last wait cycle restarts the wait, not the core
        if (waitDone && !resetReq) state_nxt = ST_RUN;                  // RULE_02
      end
      ST_RUN: begin
        if (resetReq) begin
          state_nxt = ST_OPT_WAIT;
          kind_nxt  = WK_RESET;
        end else if (stopInstr) begin
          state_nxt = ST_STOP;                                          // RULE_04
          kind_nxt  = WK_IRQ;
        end else if (haltInstr) begin
          state_nxt = ST_HALT;
          kind_nxt  = WK_IRQ;
        end
      end
      ST_HALT: begin
        if (resetReq) begin
          state_nxt = ST_OPT_WAIT;                                      // RULE_01
          kind_nxt  = WK_RESET;
        end else if (haltWake) begin
          state_nxt = ST_WAKE;                                          // RULE_05
        end
      end
      ST_WAKE: begin
        if (resetReq) begin
          state_nxt = ST_OPT_WAIT;
          kind_nxt  = WK_RESET;
        end else if (waitDone) begin
          state_nxt = ST_RUN;                                           // RULE_17
        end
      end
      ST_STOP: begin
        if (resetReq) begin
          state_nxt = crystalClock ? ST_SETTLE : ST_OPT_WAIT;           // RULE_14
          kind_nxt  = WK_RESET;
        end else if (stopWake) begin
          state_nxt = crystalClock ? ST_SETTLE : ST_POST_STOP;          // RULE_06
        end
      end
      ST_SETTLE: begin
        if (resetReq) kind_nxt = WK_RESET;
        if (waitDone) begin
          state_nxt = (kind_nxt == WK_RESET) ? ST_OPT_WAIT : ST_POST_STOP; // RULE_14
        end
      end
      ST_POST_STOP: begin
        if (resetReq) begin
          state_nxt = ST_OPT_WAIT;
          kind_nxt  = WK_RESET;
        end else if (waitDone) begin
          state_nxt = ST_RUN;                                           // RULE_13
        end
      end
      default: begin
        state_nxt = ST_OPT_WAIT;
        kind_nxt  = WK_RESET;
      end
    endcase
  end

  // State and cause registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= ST_OPT_WAIT;
      kind_r  <= WK_RESET;
    end else begin
      state_r <= state_nxt;
      kind_r  <= kind_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Wait timer
  // ---------------------------------------------------------------

  // Load chosen on entry to each timed state
  always_comb begin
    case (state_nxt)
      ST_OPT_WAIT:  waitLoad = CNT_W'(OPT_WAIT);                        // RULE_02
      ST_SETTLE:    waitLoad = settleLoad(osc_settle_select);           // RULE_16
      ST_POST_STOP: waitLoad = CNT_W'(POST_STOP);                       // RULE_13
      ST_WAKE:      waitLoad = global_interrupt_enable ? CNT_W'(WAKE_VEC_CYC)
                                                       : CNT_W'(WAKE_NEXT_CYC); // RULE_17
      default:      waitLoad = CNT_W'(WAKE_NEXT_CYC);
    endcase
  end

  // Start on entry or on a reset that restarts the option-byte wait
  assign waitStart = ((state_nxt != state_r) || (state_r == ST_OPT_WAIT && resetReq)) &&
                     (state_nxt == ST_OPT_WAIT || state_nxt == ST_SETTLE ||
                      state_nxt == ST_POST_STOP || state_nxt == ST_WAKE);
  // Settle counts oscillator cycles, others count ref_clk
  assign waitTick  = (state_r == ST_SETTLE) ? sysOscTick : 1'b1;         // RULE_16

  wait_counter #(
    .CNT_W (CNT_W)
  ) u_wait (
    .ref_clk (ref_clk),
    .rst     (rst),
    .start   (waitStart),
    .load    (waitLoad),
    .tick    (waitTick),
    .done    (waitDone)                                                  // RULE_18
  );

  // ---------------------------------------------------------------
  // Resume pulses
  // ---------------------------------------------------------------

  assign resume = (state_r != ST_RUN) && (state_nxt == ST_RUN);

  // One-cycle pulses that tell the core how to restart
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      resetFetch <= 1'b0;
      vectorTake <= 1'b0;
      resumeNext <= 1'b0;
    end else begin
      resetFetch <= resume && (kind_r == WK_RESET);                     // RULE_01
      vectorTake <= resume && (kind_r == WK_IRQ) && global_interrupt_enable;  // RULE_03
      resumeNext <= resume && (kind_r == WK_IRQ) && !global_interrupt_enable; // RULE_15
    end
  end

  // ---------------------------------------------------------------
  // Clock and peripheral gating
  // ---------------------------------------------------------------

  // Gates follow the coming state so they change with it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cpuClockRun      <= 1'b0;
      sysOscEnable     <= 1'b1;
      portLatchHold    <= 1'b0;
      timer16Run       <= 1'b0;
      adcRun           <= 1'b0;
      intervalTimerRun <= 1'b0;
      watchdogRun      <= 1'b0;
      inHalt           <= 1'b0;
      inStop           <= 1'b0;
    end else begin
      cpuClockRun      <= (state_nxt == ST_RUN);                        // RULE_18
      sysOscEnable     <= (state_nxt != ST_STOP);                       // RULE_07
      portLatchHold    <= (state_nxt == ST_HALT) || (state_nxt == ST_STOP); // RULE_07
      timer16Run       <= (state_nxt != ST_STOP);                       // RULE_08
      adcRun           <= (state_nxt != ST_STOP);                       // RULE_08
      intervalTimerRun <= (state_nxt != ST_STOP) ||
                          (timerOnLowSpeed && !lowSpeedStoppedBySw);    // RULE_09
      watchdogRun      <= (state_nxt != ST_STOP) ||
                          (wdtOnLowSpeed && !lowSpeedStoppable);        // RULE_10
      inHalt           <= (state_nxt == ST_HALT);
      inStop           <= (state_nxt == ST_STOP);
    end
  end

endmodule : standby_mode_control

// ---- logic/standby_pkg.sv ----
// Purpose: Shared constants and types for the standby mode controller
// Assumes: ref_clk at 250 MHz; option-byte and wake waits counted in ref_clk cycles
// Notes:   Overview list below names every behaviour the controller keeps
//
// Overview of operation
// (RULE_01) Reset in light standby runs normal reset
// (RULE_02) After reset release, halt for option-byte read
// (RULE_03) Light standby: unmasked request wakes, enable picks path
// (RULE_04) Stop instruction enters deep standby
// (RULE_05) Pending unmasked request at entry leaves standby
// (RULE_06) Immediate deep cancel still waits settle, stop
// (RULE_07) Deep standby stops oscillator, CPU; latches hold
// (RULE_08) Deep standby stops timer16, ADC, fast-clocked timer
// (RULE_09) Low-speed-clocked interval timer keeps running unless stopped
// (RULE_10) Watchdog runs only on non-stoppable low-speed clock
// (RULE_11) Timer, detector, external requests release deep standby
// (RULE_12) Interval timer wakes only on low-speed clock
// (RULE_13) Deep wake stops operation about 34 us
// (RULE_14) Reset in deep standby waits settle first
// (RULE_15) Deep standby: enable picks path, masked stays
// (RULE_16) Settle select chooses 2^10/12/15/17 oscillator cycles
// (RULE_17) Light wake delay 11-13 vectored, 3-5 otherwise
// (RULE_18) Waits run on live clock, done pulse ungates
package standby_pkg;

  // Clock rate and printed times
  localparam int CLK_MHZ        = 250;
  localparam int OPT_WAIT_US    = 544;   // Option-byte read halt, typical
  localparam int POST_STOP_US   = 34;    // Stop after deep wake, typical
  localparam int OPT_WAIT_CYC   = OPT_WAIT_US * CLK_MHZ;
  localparam int POST_STOP_CYC  = POST_STOP_US * CLK_MHZ;

  // Light standby wake delays in clocks
  localparam int WAKE_VEC_CYC   = 12;    // Within 11 to 13
  localparam int WAKE_NEXT_CYC  = 4;     // Within 3 to 5

  // Oscillator settle exponents per select code
  localparam int SETTLE_EXP0    = 10;
  localparam int SETTLE_EXP1    = 12;
  localparam int SETTLE_EXP2    = 15;
  localparam int SETTLE_EXP3    = 17;

  // Default wake sources
  localparam int NUM_IRQ_DEF    = 8;
  localparam int TIMER_IRQ_DEF  = 0;
  localparam logic [7:0] STOP_WAKE_DEF = 8'h0f;

  typedef enum {
    ST_OPT_WAIT,
    ST_RUN,
    ST_HALT,
    ST_WAKE,
    ST_STOP,
    ST_SETTLE,
    ST_POST_STOP
  } standby_state_t;

  typedef enum {
    WK_RESET,
    WK_IRQ
  } wake_kind_t;

endpackage : standby_pkg

// ---- logic/wait_counter.sv ----
// Purpose: Down counter that times one wait and pulses when it ends
// Assumes: start and tick synchronous to clk; load at least one
// Notes:   A start while busy reloads the count
`timescale 1ns/1ps
module wait_counter #(
  parameter int CNT_W = 18
) (
  input  wire logic             ref_clk,   // Always-running clock
  input  wire logic             rst,       // Synchronous reset
  input  wire logic             start,     // Load and begin
  input  wire logic [CNT_W-1:0] load,      // Ticks to wait
  input  wire logic             tick,      // Count enable
  output logic                  done       // One-cycle end pulse
);

  logic [CNT_W-1:0] cnt_r;
  logic             busy_r;
  logic             done_r;

  // Count ticks down to zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else if (start) begin
      cnt_r  <= load;
      busy_r <= 1'b1;
      done_r <= 1'b0;
    end else if (busy_r && tick) begin
      cnt_r  <= cnt_r - 1'b1;
      busy_r <= (cnt_r != {{(CNT_W-1){1'b0}}, 1'b1});
      done_r <= (cnt_r == {{(CNT_W-1){1'b0}}, 1'b1}); // RULE_18
    end else begin
      done_r <= 1'b0;
    end
  end

  assign done = done_r;

endmodule : wait_counter

// ---- verif/standby_mode_control_asserts.sv ----
// Purpose: Port checks for the standby mode controller
// Assumes: One clock domain, bound to the top module
// Notes:   Wait figures follow the bound parameters
`timescale 1ns/1ps
module standby_mode_control_asserts #(
  parameter int                 NUM_IRQ   = 8,
  parameter int                 TIMER_IRQ = 0,
  parameter logic [NUM_IRQ-1:0] STOP_WAKE = '1,
  parameter int                 OPT_WAIT  = 20,
  parameter int                 POST_STOP = 10
) (
  input wire logic               ref_clk,                 // Clock
  input wire logic               rst,                     // Reset
  input wire logic               resetReq,                // Chip reset
  input wire logic [NUM_IRQ-1:0] irqRequest,              // Requests
  input wire logic [NUM_IRQ-1:0] interrupt_mask_flag,     // Masks
  input wire logic               global_interrupt_enable, // Enable
  input wire logic               crystalClock,            // Crystal
  input wire logic               timerOnLowSpeed,         // Timer slow clk
  input wire logic               lowSpeedStoppedBySw,     // Slow osc off
  input wire logic               wdtOnLowSpeed,           // Watchdog slow clk
  input wire logic               lowSpeedStoppable,       // Slow osc stoppable
  input wire logic               cpuClockRun,             // Core clock
  input wire logic               sysOscEnable,            // Oscillator
  input wire logic               timer16Run,              // Timer16
  input wire logic               adcRun,                  // A/D
  input wire logic               intervalTimerRun,        // Interval timer
  input wire logic               portLatchHold,           // Port latches frozen
  input wire logic               watchdogRun,             // Watchdog
  input wire logic               inHalt,                  // Light standby
  input wire logic               inStop,                  // Deep standby
  input wire logic               resetFetch,              // Reset pulse
  input wire logic               vectorTake,              // Vector pulse
  input wire logic               resumeNext               // Next pulse
);
  // Deep wake sources, gated-clock gap, last standby was deep without crystal clock
  logic [NUM_IRQ-1:0] live;
  int                 gap;
  logic               fromStop;
  assign live = irqRequest & ~interrupt_mask_flag & STOP_WAKE
              & ~(timerOnLowSpeed ? '0 : NUM_IRQ'(1) << TIMER_IRQ);
  always_ff @(posedge ref_clk) begin
    if (rst || inStop || cpuClockRun) gap <= 0;
    else gap <= gap + 1;
    if (rst || inHalt) fromStop <= 1'b0;
    else if (inStop) fromStop <= !crystalClock;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_stop_gates; inStop |-> !(sysOscEnable || cpuClockRun || timer16Run || adcRun); endproperty
  a_stop_gates: assert property (p_stop_gates) else $error("gate open in stop");
  property p_itimer; inStop && $past(inStop) |->
    intervalTimerRun == ($past(timerOnLowSpeed) && !$past(lowSpeedStoppedBySw)); endproperty
  a_itimer: assert property (p_itimer) else $error("interval timer gate");
  property p_wdt; inStop && $past(inStop) |->
    watchdogRun == ($past(wdtOnLowSpeed) && !$past(lowSpeedStoppable)); endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog gate");
  property p_latch_hold; portLatchHold == (inHalt || inStop); endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("port latch hold");
  property p_halt_wake; inHalt && |(irqRequest & ~interrupt_mask_flag) |=> !inHalt; endproperty
  a_halt_wake: assert property (p_halt_wake) else $error("halt not left");
  property p_stop_wake; inStop && |live |=> !inStop; endproperty
  a_stop_wake: assert property (p_stop_wake) else $error("stop not left");
  property p_stop_hold; inStop && !resetReq && !(|live) |=> inStop; endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop left");
  property p_vec_time; $fell(inHalt) && !$past(resetReq) && global_interrupt_enable |->
    !cpuClockRun [*8] ##[1:10] (cpuClockRun && vectorTake); endproperty
  a_vec_time: assert property (p_vec_time) else $error("halt wake delay");
  property p_next_time; $fell(inHalt) && !$past(resetReq) && !global_interrupt_enable |->
    !cpuClockRun [*2] ##[1:6] (cpuClockRun && resumeNext); endproperty
  a_next_time: assert property (p_next_time) else $error("halt next delay");
  property p_post_stop; $rose(cpuClockRun) && fromStop && !resetFetch |->
    gap >= POST_STOP - 1 && gap <= POST_STOP + 4; endproperty
  a_post_stop: assert property (p_post_stop) else $error("post stop wait");
  property p_opt_wait; $rose(cpuClockRun) && resetFetch |-> gap >= OPT_WAIT; endproperty
  a_opt_wait: assert property (p_opt_wait) else $error("option wait short");
  property p_one_pulse; $rose(cpuClockRun) || resetFetch || vectorTake || resumeNext |->
    $rose(cpuClockRun) && $onehot({resetFetch, vectorTake, resumeNext}); endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("resume pulse");
endmodule : standby_mode_control_asserts
bind standby_mode_control standby_mode_control_asserts #(.NUM_IRQ(NUM_IRQ),
  .TIMER_IRQ(TIMER_IRQ), .STOP_WAKE(STOP_WAKE), .OPT_WAIT(OPT_WAIT), .POST_STOP(POST_STOP)
) standby_mode_control_asserts_i (.ref_clk(ref_clk), .rst(rst), .resetReq(resetReq),
  .irqRequest(irqRequest), .interrupt_mask_flag(interrupt_mask_flag),
  .global_interrupt_enable(global_interrupt_enable), .crystalClock(crystalClock),
  .timerOnLowSpeed(timerOnLowSpeed), .lowSpeedStoppedBySw(lowSpeedStoppedBySw),
  .wdtOnLowSpeed(wdtOnLowSpeed), .lowSpeedStoppable(lowSpeedStoppable),
  .portLatchHold(portLatchHold), .watchdogRun(watchdogRun),
  .cpuClockRun(cpuClockRun), .sysOscEnable(sysOscEnable), .timer16Run(timer16Run),
  .adcRun(adcRun), .intervalTimerRun(intervalTimerRun), .inHalt(inHalt), .inStop(inStop),
  .resetFetch(resetFetch), .vectorTake(vectorTake), .resumeNext(resumeNext));

// ---- verif/cpu_core_model.sv ----
// Purpose: Core model issuing halt and stop instructions
// Assumes: Bench requests are one cycle wide
// Notes:   A gated core executes nothing
`timescale 1ns/1ps
module cpu_core_model (
  input  wire logic ref_clk,           // Clock
  input  wire logic cpuClockRun,       // Core clock gate
  input  wire logic wantHalt,          // Halt request
  input  wire logic wantStop,          // Stop request
  output logic      haltInstr = 1'b0,  // Halt pulse
  output logic      stopInstr = 1'b0   // Stop pulse
);
  // Instruction pulses only while the core clock runs
  always @(posedge ref_clk) begin
    haltInstr <= #1 wantHalt && cpuClockRun;
    stopInstr <= #1 wantStop && cpuClockRun;
  end
endmodule : cpu_core_model

// ---- verif/standby_mode_control_bench.sv ----
// Purpose: Self-checking bench for the standby mode controller
// Assumes: Short option and post-stop waits set below
// Notes:   Table rows cover wake paths; reset and settle cases follow
`timescale 1ns/1ps
module standby_mode_control_bench;
  localparam int OW = 20;  // Option wait
  localparam int PS = 10;  // Post-stop wait
  typedef struct {logic stp; logic [7:0] irq; logic [7:0] msk; logic ie; logic tls; int k;} row_t;
  // Wake kind: 0 held, 1 vectored, 2 next
  row_t rows[9] = '{'{0,8'h01,8'h00,1,0,1}, '{0,8'h01,8'h00,0,0,2}, '{0,8'h02,8'h02,1,0,0},
    '{1,8'h02,8'h00,1,0,1}, '{1,8'h04,8'h00,0,0,2}, '{1,8'h20,8'h00,1,0,0},
    '{1,8'h01,8'h00,1,0,0}, '{1,8'h01,8'h00,1,1,1}, '{1,8'h08,8'h08,0,1,0}};
  logic       ref_clk = 0, rst = 1, resetReq = 0, wantHalt = 0, wantStop = 0, ie = 0;
  logic       xtal = 0, tls = 0, swStop = 0, oscTick = 0;
  logic [7:0] irq = 0, msk = 0;
  logic [1:0] sel = 0;
  logic       haltInstr, stopInstr, run, oscOn, inHalt, inStop, fetch, vecTake, nextRes;
  int         errCount = 0, checkCount = 0, cycles = 0, k, n, t;
  always #2 ref_clk = ~ref_clk;
  // System oscillator ticks at half the clock rate
  always @(posedge ref_clk) oscTick <= #1 !oscTick;
  cpu_core_model cpu_core_model_i (.ref_clk(ref_clk), .cpuClockRun(run), .wantHalt(wantHalt),
    .wantStop(wantStop), .haltInstr(haltInstr), .stopInstr(stopInstr));
  standby_mode_control #(.OPT_WAIT(OW), .POST_STOP(PS)) standby_mode_control_i (
    .ref_clk(ref_clk), .rst(rst), .resetReq(resetReq), .haltInstr(haltInstr),
    .stopInstr(stopInstr), .irqRequest(irq), .interrupt_mask_flag(msk),
    .global_interrupt_enable(ie), .osc_settle_select(sel), .sysOscTick(oscTick),
    .crystalClock(xtal), .timerOnLowSpeed(tls), .wdtOnLowSpeed(tls),
    .lowSpeedStoppable(swStop), .lowSpeedStoppedBySw(swStop), .cpuClockRun(run),
    .sysOscEnable(oscOn), .portLatchHold(), .timer16Run(), .adcRun(), .intervalTimerRun(),
    .watchdogRun(), .inHalt(inHalt), .inStop(inStop), .resetFetch(fetch),
    .vectorTake(vecTake), .resumeNext(nextRes));
  task automatic close_out;
    $display("checks %0d errors %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checkCount++;
    if (g !== e) begin
      errCount++;
      $display("[ERR] %s exp %0d got %0d", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask : cyc
  // Wait for a resume pulse: 1 vectored, 2 next, 3 reset fetch
  task automatic wait_pulse(input int lim, output int kk, output int nn);
    kk = 0;
    nn = 0;
    while (kk == 0 && nn < lim) begin
      cyc(1);
      nn++;
      kk = vecTake === 1'b1 ? 1 : nextRes === 1'b1 ? 2 : fetch === 1'b1 ? 3 : 0;
    end
  endtask : wait_pulse
  task automatic enter(input logic s);
    wantHalt = !s;
    wantStop = s;
    cyc(1);
    wantHalt = 0;
    wantStop = 0;
  endtask : enter
  task automatic chip_reset;
    resetReq = 1;
    cyc(1);
    resetReq = 0;
  endtask : chip_reset
  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles > 20000) begin
      errCount++;
      close_out;
    end
  end
  initial begin
    cyc(8);
    chk("osc in reset", 1, oscOn);
    rst = 0;
    chip_reset;
    wait_pulse(200, k, n);
    chk("boot fetch", 3, k);
    foreach (rows[i]) begin
      {irq, msk, ie, tls, swStop} = {rows[i].irq, rows[i].msk, rows[i].ie, rows[i].tls, i == 8};
      enter(rows[i].stp);
      wait_pulse(60, k, n);
      chk("wake kind", rows[i].k, k);
      irq = 0;
      if (k == 0) begin
        chk("held", 1, rows[i].stp ? inStop : inHalt);
        chip_reset;
        wait_pulse(200, k, n);
        chk("reset exit", 3, k);
      end
    end
    xtal = 1;
    for (int s = 0; s < 2; s++) begin
      {sel, irq, ie} = {s[1:0], 8'h02, 1'b1};
      enter(1);
      wait_pulse(9000, k, n);
      chk("settle wake", 1, k);
      t = 2 << (10 + 2 * s);  // Settle cycles at half-rate ticks
      chk("settle time", 1, n >= t + PS - 2 && n <= t + PS + 8);
      irq = 0;
    end
    sel = 0;
    enter(1);
    cyc(5);
    chk("in stop", 1, inStop);
    chip_reset;
    wait_pulse(3000, k, n);
    chk("stop reset", 3, k);
    chk("stop reset wait", 1, n >= (2 << 10) + OW - 4 && n <= (2 << 10) + OW + 8);
    close_out;
  end
endmodule : standby_mode_control_bench
